// ===== rtl/hpt_defs.svh
// Constants of the host port: access select codes, reset values, timing counts.
// Assumes a single 20 MHz system clock shared by both ends of the port.
`ifndef HPT_DEFS_SVH
`define HPT_DEFS_SVH

// Access select field codes
`define HPT_SEL_CTRL      2'h0
`define HPT_SEL_DATA_INC  2'h1
`define HPT_SEL_ADDR      2'h2
`define HPT_SEL_DATA      2'h3

// Reset values and address increment step
`define HPT_CTRL_RST      16'h0000
`define HPT_ADDR_RST      32'h00000000
`define HPT_ADDR_STEP     32'h00000004

// Timing: clock period and least strobe low/high time, both in ns
`define HPT_CLK_NS        50
`define HPT_STB_MIN_NS    100
`define HPT_STB_MIN_CYC   ((`HPT_STB_MIN_NS + `HPT_CLK_NS - 1) / `HPT_CLK_NS)
// Cycles the host waits before trusting ready, covering both synchronisers
`define HPT_RDY_SETTLE    8

// Write-commit buffer shape
`define HPT_FIFO_WIDTH    64
`define HPT_FIFO_DEPTH    16

`endif

// ===== rtl/hpt_pkg.sv
// Types shared by both ends of the host port.
// Assumes hpt_defs.svh supplies the numeric constants.
package hpt_pkg;

    // Device end pending-operation state
    typedef enum logic [1:0] {
        DEV_IDLE,
        DEV_FETCH,
        DEV_PREF,
        DEV_COMMIT
    } hpt_dev_state_t;

    // Host end access sequencing state
    typedef enum logic [1:0] {
        HOST_IDLE,
        HOST_SETUP,
        HOST_STROBE,
        HOST_RECOVER
    } hpt_host_state_t;

endpackage : hpt_pkg

// ===== rtl/hpt_if.sv
// Pin bundle between the external host and the device's host port.
// The shared data bus is resolved here from the two output enables.
`timescale 1ns/1ns
interface hpt_if;
    logic        host_chip_select_n;
    logic        data_strobe_a_n;
    logic        data_strobe_b_n;
    logic        address_strobe_n;
    logic [1:0]  access_select_field;
    logic        host_read_not_write;
    logic        halfword_select;
    logic        host_ready_n;
    logic [15:0] host_data_o;
    logic        host_data_oe_n;
    logic [15:0] dev_data_o;
    logic        dev_data_oe_n;
    logic [15:0] host_data_bus;

    // Undriven bus reads as all ones, as a pulled-up wire would
    assign host_data_bus = !dev_data_oe_n  ? dev_data_o :
                           !host_data_oe_n ? host_data_o : 16'hFFFF;

    modport device (
        input  host_chip_select_n, data_strobe_a_n, data_strobe_b_n, address_strobe_n,
        input  access_select_field, host_read_not_write, halfword_select, host_data_bus,
        output host_ready_n, dev_data_o, dev_data_oe_n
    );

    modport host (
        output host_chip_select_n, data_strobe_a_n, data_strobe_b_n, address_strobe_n,
        output access_select_field, host_read_not_write, halfword_select,
        output host_data_o, host_data_oe_n,
        input  host_ready_n, host_data_bus
    );
endinterface : hpt_if

// ===== rtl/hpt_device.sv
// Device end of the host port plus its write-commit FIFO.
// Assumes pins arrive asynchronously; memory side is on sys_clk.
`timescale 1ns/1ns
`include "hpt_defs.svh"

module hpt_fifo #(
    parameter int WIDTH = `HPT_FIFO_WIDTH,
    parameter int DEPTH = `HPT_FIFO_DEPTH
) (
    input  wire logic             sys_clk,
    input  wire logic             rst,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wptr;
    logic [AW-1:0]    rptr;
    logic [AW:0]      count;
    logic [AW-1:0]    next_wptr;
    logic [AW-1:0]    next_rptr;
    logic [AW:0]      next_count;
    logic             next_in_ready;
    logic             next_out_valid;
    logic             push;
    logic             pop;

    // Full and empty are registered from the next count, so they track it exactly
    assign out_data  = mem[rptr];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    // Pointer and occupancy update
    always_comb begin
        next_wptr  = push ? wptr + 1'b1 : wptr;
        next_rptr  = pop ? rptr + 1'b1 : rptr;
        next_count = count;
        if (push && !pop) begin
            next_count = count + 1'b1;
        end else if (pop && !push) begin
            next_count = count - 1'b1;
        end
        next_in_ready  = (next_count != (AW+1)'(DEPTH));
        next_out_valid = (next_count != '0);
    end

    // Storage array carries no reset; only the pointers, count and flags need one
    always_ff @(posedge sys_clk) begin
        if (push) begin
            mem[wptr] <= in_data;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            wptr      <= '0;
            rptr      <= '0;
            count     <= '0;
            in_ready  <= 1'b1;
            out_valid <= 1'b0;
        end else begin
            wptr      <= next_wptr;
            rptr      <= next_rptr;
            count     <= next_count;
            in_ready  <= next_in_ready;
            out_valid <= next_out_valid;
        end
    end
endmodule : hpt_fifo

module hpt_device (
    input  wire logic        sys_clk,
    input  wire logic        rst,
    hpt_if.device            port,
    output logic             fetch_req,
    output logic [31:0]      fetch_addr,
    input  wire logic        fetch_valid,
    input  wire logic [31:0] fetch_data,
    output logic             commit_valid,
    input  wire logic        commit_ready,
    output logic [63:0]      commit_word,
    output logic [15:0]      control_value
);
    logic [23:0]            in_meta;
    logic [23:0]            in_sync;
    logic                   cs_s;
    logic                   has_s;
    logic [3:0]             sel_now;
    logic [15:0]            hd_s;
    logic                   stb_n;
    logic                   stb_prev;
    logic                   has_prev;
    logic                   stb_fall;
    logic                   stb_rise;
    logic                   has_fall;
    logic [3:0]             acc;
    logic [3:0]             lat;
    logic                   has_hold;
    hpt_pkg::hpt_dev_state_t state;
    logic [15:0]            ctrl;
    logic [31:0]            addr;
    logic [31:0]            data;
    logic [15:0]            wlow;
    logic                   data_ok;
    logic                   push_valid;
    logic [63:0]            push_word;
    logic                   push_ready;
    logic [15:0]            hd_o;
    logic                   oe_n;
    logic                   rdy_n;
    logic [3:0]             next_lat;
    logic                   next_has_hold;
    hpt_pkg::hpt_dev_state_t next_state;
    logic [15:0]            next_ctrl;
    logic [31:0]            next_addr;
    logic [31:0]            next_data;
    logic [15:0]            next_wlow;
    logic                   next_data_ok;
    logic                   next_push_valid;
    logic [63:0]            next_push_word;
    logic                   next_req;
    logic [31:0]            next_req_addr;
    logic [15:0]            next_hd_o;
    logic                   next_oe_n;
    logic                   next_rdy_n;

    // Two-flop synchroniser on every pin; only in_sync is looked at
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            in_meta <= 24'hFFFFFF;
            in_sync <= 24'hFFFFFF;
        end else begin
            in_meta <= {port.host_chip_select_n, port.data_strobe_a_n, port.data_strobe_b_n,
                        port.address_strobe_n, port.access_select_field,
                        port.host_read_not_write, port.halfword_select, port.host_data_bus};
            in_sync <= in_meta;
        end
    end

    assign cs_s    = in_sync[23];
    assign has_s   = in_sync[20];
    assign sel_now = in_sync[19:16];
    assign hd_s    = in_sync[15:0];
    assign stb_n   = ~(in_sync[22] ^ in_sync[21]) | cs_s;
    assign stb_fall = stb_prev && !stb_n;
    assign stb_rise = !stb_prev && stb_n;
    assign has_fall = has_prev && !has_s;
    // Select group comes from the address strobe latch when one was seen
    assign acc = has_hold ? lat : sel_now;

    // Access decode, pending operation and pin drive
    always_comb begin
        next_lat        = lat;
        next_has_hold   = has_hold;
        next_state      = state;
        next_ctrl       = ctrl;
        next_addr       = addr;
        next_data       = data;
        next_wlow       = wlow;
        next_data_ok    = data_ok;
        next_push_valid = push_valid;
        next_push_word  = push_word;
        next_req        = 1'b0;
        next_req_addr   = fetch_addr;
        next_oe_n       = oe_n;
        if (has_fall && stb_n) begin
            next_lat      = sel_now;
            next_has_hold = 1'b1;
        end
        if (stb_fall) begin
            next_lat      = acc;
            next_has_hold = 1'b0;
            if (acc[1]) begin
                next_oe_n = 1'b0;
                // Fixed reads fetch only when no operation is pending; increment reads use a valid prefetch
                if (acc[3:2] inside {`HPT_SEL_DATA, `HPT_SEL_DATA_INC} && !acc[0] &&
                    (acc[3:2] == `HPT_SEL_DATA || !data_ok) && state == hpt_pkg::DEV_IDLE) begin
                    next_state    = hpt_pkg::DEV_FETCH;
                    next_req      = 1'b1;
                    next_req_addr = addr;
                end
            end
        end
        if (stb_rise) begin
            next_oe_n = 1'b1;
            if (lat[1]) begin
                if (lat[0] && lat[3:2] == `HPT_SEL_DATA_INC) begin
                    next_addr     = addr + `HPT_ADDR_STEP;
                    next_data_ok  = 1'b0;
                    next_state    = hpt_pkg::DEV_PREF;
                    next_req      = 1'b1;
                    next_req_addr = addr + `HPT_ADDR_STEP;
                end else if (lat[0] && lat[3:2] == `HPT_SEL_DATA) begin
                    next_data_ok = 1'b0;
                end
            end else begin
                unique case (lat[3:2])
                    `HPT_SEL_CTRL: next_ctrl = hd_s;
                    `HPT_SEL_ADDR: begin
                        if (lat[0]) begin
                            next_addr[31:16] = hd_s;
                        end else begin
                            next_addr[15:0] = hd_s;
                        end
                        next_data_ok = 1'b0;
                    end
                    `HPT_SEL_DATA, `HPT_SEL_DATA_INC: begin
                        if (!lat[0]) begin
                            next_wlow = hd_s;
                        end else begin
                            // Word carries the address it belongs to
                            next_push_word  = {addr, hd_s, wlow};
                            next_push_valid = 1'b1;
                            next_data_ok    = 1'b0;
                            next_state      = hpt_pkg::DEV_COMMIT;
                            if (lat[3:2] == `HPT_SEL_DATA_INC) begin
                                next_addr = addr + `HPT_ADDR_STEP;
                            end
                        end
                    end
                endcase
            end
        end
        unique case (state)
            hpt_pkg::DEV_IDLE: begin
            end
            hpt_pkg::DEV_FETCH, hpt_pkg::DEV_PREF: begin
                if (fetch_valid) begin
                    next_data    = fetch_data;
                    next_data_ok = 1'b1;
                    next_state   = hpt_pkg::DEV_IDLE;
                end
            end
            hpt_pkg::DEV_COMMIT: begin
                // A full buffer stretches the busy time seen by the host
                if (push_ready) begin
                    next_push_valid = 1'b0;
                    next_state      = hpt_pkg::DEV_IDLE;
                end
            end
        endcase
        // Read data follows next values so it leads ready by a cycle
        unique case (next_lat[3:2])
            `HPT_SEL_CTRL: next_hd_o = next_ctrl;
            `HPT_SEL_ADDR: next_hd_o = next_lat[0] ? next_addr[31:16] : next_addr[15:0];
            default:       next_hd_o = next_lat[0] ? next_data[31:16] : next_data[15:0];
        endcase
        // Busy holds ready high; a deselected port always shows ready low
        next_rdy_n = cs_s ? 1'b0 : (state != hpt_pkg::DEV_IDLE);
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            stb_prev   <= 1'b1;
            has_prev   <= 1'b1;
            lat        <= 4'h0;
            has_hold   <= 1'b0;
            state      <= hpt_pkg::DEV_IDLE;
            ctrl       <= `HPT_CTRL_RST;
            addr       <= `HPT_ADDR_RST;
            data       <= 32'h00000000;
            wlow       <= 16'h0000;
            data_ok    <= 1'b0;
            push_valid <= 1'b0;
            push_word  <= 64'h0000000000000000;
            fetch_req  <= 1'b0;
            fetch_addr <= `HPT_ADDR_RST;
            hd_o       <= 16'h0000;
            oe_n       <= 1'b1;
            rdy_n      <= 1'b0;
        end else begin
            stb_prev   <= stb_n;
            has_prev   <= has_s;
            lat        <= next_lat;
            has_hold   <= next_has_hold;
            state      <= next_state;
            ctrl       <= next_ctrl;
            addr       <= next_addr;
            data       <= next_data;
            wlow       <= next_wlow;
            data_ok    <= next_data_ok;
            push_valid <= next_push_valid;
            push_word  <= next_push_word;
            fetch_req  <= next_req;
            fetch_addr <= next_req_addr;
            hd_o       <= next_hd_o;
            oe_n       <= next_oe_n;
            rdy_n      <= next_rdy_n;
        end
    end

    // Committed writes queue here so memory back-pressure stalls the port
    hpt_fifo #(
        .WIDTH (`HPT_FIFO_WIDTH),
        .DEPTH (`HPT_FIFO_DEPTH)
    ) u_commit_fifo (
        .sys_clk   (sys_clk),
        .rst       (rst),
        .in_valid  (push_valid),
        .in_ready  (push_ready),
        .in_data   (push_word),
        .out_valid (commit_valid),
        .out_ready (commit_ready),
        .out_data  (commit_word)
    );

    assign control_value      = ctrl;
    assign port.dev_data_o    = hd_o;
    assign port.dev_data_oe_n = oe_n;
    assign port.host_ready_n  = rdy_n;
endmodule : hpt_device

// ===== rtl/hpt_host.sv
// Host end of the host port: turns word commands into two half-word strobes.
// Assumes the device answers on the pins; ready and data are synchronised here.
`timescale 1ns/1ns
`include "hpt_defs.svh"

module hpt_host (
    input  wire logic        sys_clk,
    input  wire logic        rst,
    hpt_if.host              port,
    input  wire logic        cmd_valid,
    output logic             cmd_ready,
    input  wire logic [1:0]  cmd_sel,
    input  wire logic        cmd_read,
    input  wire logic [31:0] cmd_wdata,
    output logic             rsp_valid,
    output logic [31:0]      rsp_data
);
    localparam logic [3:0] STB_LAST = 4'(`HPT_STB_MIN_CYC - 1);
    localparam logic [3:0] RDY_LAST = 4'(`HPT_RDY_SETTLE - 1);

    logic [16:0]              in_meta;
    logic [16:0]              in_sync;
    hpt_pkg::hpt_host_state_t state;
    hpt_pkg::hpt_host_state_t next_state;
    logic [3:0]               cnt;
    logic [3:0]               next_cnt;
    logic [1:0]               sel;
    logic [1:0]               next_sel;
    logic                     rd;
    logic                     next_rd;
    logic [31:0]              wdata;
    logic [31:0]              next_wdata;
    logic                     hw;
    logic                     next_hw;
    logic                     cs_n;
    logic                     next_cs_n;
    logic                     dsa_n;
    logic                     next_dsa_n;
    logic [15:0]              hd_o;
    logic [15:0]              next_hd_o;
    logic                     oe_n;
    logic                     next_oe_n;
    logic [31:0]              next_rsp_data;
    logic                     next_rsp_valid;
    logic                     next_cmd_ready;

    // Ready and data bus pass two flops before use
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            in_meta <= 17'h00000;
            in_sync <= 17'h00000;
        end else begin
            in_meta <= {port.host_ready_n, port.host_data_bus};
            in_sync <= in_meta;
        end
    end

    // Access sequencer: setup, strobe low, strobe high, per half-word
    always_comb begin
        next_state     = state;
        next_cnt       = cnt;
        next_sel       = sel;
        next_rd        = rd;
        next_wdata     = wdata;
        next_hw        = hw;
        next_cs_n      = cs_n;
        next_dsa_n     = dsa_n;
        next_hd_o      = hd_o;
        next_oe_n      = oe_n;
        next_rsp_data  = rsp_data;
        next_rsp_valid = 1'b0;
        next_cmd_ready = cmd_ready;
        unique case (state)
            hpt_pkg::HOST_IDLE: begin
                if (cmd_valid && cmd_ready) begin
                    next_sel       = cmd_sel;
                    next_rd        = cmd_read;
                    next_wdata     = cmd_wdata;
                    next_hw        = 1'b0;
                    next_cs_n      = 1'b0;
                    next_hd_o      = cmd_wdata[15:0];
                    next_oe_n      = cmd_read;
                    next_cmd_ready = 1'b0;
                    next_state     = hpt_pkg::HOST_SETUP;
                end else begin
                    // Port opens on the first edge after reset and stays open while idle
                    next_cmd_ready = 1'b1;
                end
            end
            hpt_pkg::HOST_SETUP: begin
                // Select group has been stable a full cycle before the fall
                next_dsa_n = 1'b0;
                next_cnt   = 4'h0;
                next_state = hpt_pkg::HOST_STROBE;
            end
            hpt_pkg::HOST_STROBE: begin
                // Wait long enough for a busy ready to reach us, then for low
                if (cnt != RDY_LAST) begin
                    next_cnt = cnt + 4'h1;
                end else if (!in_sync[16]) begin
                    if (hw) begin
                        next_rsp_data[31:16] = in_sync[15:0];
                    end else begin
                        next_rsp_data[15:0] = in_sync[15:0];
                    end
                    next_dsa_n = 1'b1;
                    next_cnt   = 4'h0;
                    next_state = hpt_pkg::HOST_RECOVER;
                end
            end
            hpt_pkg::HOST_RECOVER: begin
                if (cnt != STB_LAST) begin
                    next_cnt = cnt + 4'h1;
                end else if (!hw) begin
                    next_hw    = 1'b1;
                    next_hd_o  = wdata[31:16];
                    next_state = hpt_pkg::HOST_SETUP;
                end else begin
                    next_cs_n      = 1'b1;
                    next_oe_n      = 1'b1;
                    next_rsp_valid = rd;
                    next_cmd_ready = 1'b1;
                    next_state     = hpt_pkg::HOST_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            state     <= hpt_pkg::HOST_IDLE;
            cnt       <= 4'h0;
            sel       <= 2'h0;
            rd        <= 1'b1;
            wdata     <= 32'h00000000;
            hw        <= 1'b0;
            cs_n      <= 1'b1;
            dsa_n     <= 1'b1;
            hd_o      <= 16'h0000;
            oe_n      <= 1'b1;
            rsp_data  <= 32'h00000000;
            rsp_valid <= 1'b0;
            cmd_ready <= 1'b0;
        end else begin
            state     <= next_state;
            cnt       <= next_cnt;
            sel       <= next_sel;
            rd        <= next_rd;
            wdata     <= next_wdata;
            hw        <= next_hw;
            cs_n      <= next_cs_n;
            dsa_n     <= next_dsa_n;
            hd_o      <= next_hd_o;
            oe_n      <= next_oe_n;
            rsp_data  <= next_rsp_data;
            rsp_valid <= next_rsp_valid;
            cmd_ready <= next_cmd_ready;
        end
    end

    // Second strobe parked high; first strobe alone toggles the access
    assign port.host_chip_select_n  = cs_n;
    assign port.data_strobe_a_n     = dsa_n;
    assign port.data_strobe_b_n     = 1'b1;
    assign port.address_strobe_n    = 1'b1;
    assign port.access_select_field = sel;
    assign port.host_read_not_write = rd;
    assign port.halfword_select     = hw;
    assign port.host_data_o         = hd_o;
    assign port.host_data_oe_n      = oe_n;
endmodule : hpt_host

// ===== rtl/hpt_note_end.sv
`timescale 1ns/1ns

// ===== test/hpt_checker_sva.sv
// Checker for the host port pins between the two ends.
// Assumes the bench clock and reset; sees interface signals only.
`timescale 1ns/1ns
module hpt_checker (
    input logic       sys_clk,
    input logic       rst,
    input logic       host_chip_select_n,
    input logic       data_strobe_a_n,
    input logic       data_strobe_b_n,
    input logic [1:0] access_select_field,
    input logic       host_read_not_write,
    input logic       halfword_select,
    input logic       host_ready_n,
    input logic       dev_data_oe_n
);
    // Combined strobe, formed as the device forms it
    wire stb = ~(data_strobe_a_n ^ data_strobe_b_n) | host_chip_select_n;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    // Four cycles covers the select synchroniser
    a_ready_off_idle: assert property (host_chip_select_n [*4] |-> !host_ready_n)
        else $error("ready not low while deselected");
    a_bus_release: assert property (stb [*5] |-> dev_data_oe_n)
        else $error("bus still driven after strobe rise");
    a_strobe_low_min: assert property ($fell(stb) |-> !stb [*2])
        else $error("strobe low too short");
    a_strobe_high_min: assert property ($rose(stb) |-> stb [*2])
        else $error("strobe high too short");
    a_hold_for_ready: assert property ($rose(stb) |-> $past(host_ready_n) == 1'b0)
        else $error("strobe released before ready");
    a_select_hold: assert property ($fell(stb) |-> ##1
        $stable({access_select_field, host_read_not_write, halfword_select}))
        else $error("select group moved at strobe fall");
    a_fetch_busy: assert property ($fell(stb) && access_select_field == 2'h3
        && host_read_not_write && !halfword_select |-> ##[1:6] host_ready_n)
        else $error("no busy on fixed read");
    // Ready seen low after the select sync means nothing was pending
    a_ctrl_ready_kept: assert property ($fell(stb) && !access_select_field[0]
        ##3 !host_ready_n |-> !host_ready_n [*6])
        else $error("ready moved on control or address access");
endmodule : hpt_checker

// ===== test/host_port_interface_test.sv
// Bench joining host and device ends; memory side is modelled here.
// Assumes the rtl files are compiled first.
`timescale 1ns/1ns
module host_port_interface_test;
    localparam logic [31:0] K = 32'hA5C3_0000; // Memory content pattern
    logic        sys_clk, rst, cmd_valid, cmd_ready, cmd_read, rsp_valid, fetch_req;
    logic        fetch_valid, commit_valid, commit_ready;
    logic [1:0]  cmd_sel;
    logic [15:0] control_value;
    logic [31:0] cmd_wdata, rsp_data, fetch_addr, fetch_data, r;
    logic [63:0] commit_word;
    int          errors = 0, n_tests = 0, pend = 0;
    hpt_if hpt_if_i ();
    hpt_host hpt_host_i (.port(hpt_if_i.host), .*);
    hpt_device hpt_device_i (.port(hpt_if_i.device), .*);
    hpt_checker hpt_checker_i (.sys_clk(sys_clk), .rst(rst),
        .host_chip_select_n(hpt_if_i.host_chip_select_n),
        .data_strobe_a_n(hpt_if_i.data_strobe_a_n), .data_strobe_b_n(hpt_if_i.data_strobe_b_n),
        .access_select_field(hpt_if_i.access_select_field),
        .host_read_not_write(hpt_if_i.host_read_not_write),
        .halfword_select(hpt_if_i.halfword_select), .host_ready_n(hpt_if_i.host_ready_n),
        .dev_data_oe_n(hpt_if_i.dev_data_oe_n));
    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end
    // Memory answers four cycles late, so the port must wait on it
    always @(negedge sys_clk) begin
        fetch_valid <= (pend == 1);
        if (fetch_req) begin
            pend <= 4;
            fetch_data <= fetch_addr ^ K;
        end else if (pend != 0) begin
            pend <= pend - 1;
        end
    end
    task automatic end_of_test();
        if (errors == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : end_of_test
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // Port free again; a few more cycles let the device act on the last strobe
    task automatic idle();
        while (cmd_ready !== 1'b1) @(negedge sys_clk);
        repeat (4) @(negedge sys_clk);
    endtask : idle
    // One word command; reads return the joined word
    task automatic xfer(input logic [1:0] sel, input logic rd, input logic [31:0] wd);
        idle();
        cmd_sel = sel;
        cmd_read = rd;
        cmd_wdata = wd;
        cmd_valid = 1'b1;
        @(negedge sys_clk);
        cmd_valid = 1'b0;
        while (rd && rsp_valid !== 1'b1) @(negedge sys_clk);
        r = rsp_data;
    endtask : xfer
    initial begin
        {rst, cmd_valid, cmd_read, commit_ready} = 4'h8;
        {cmd_sel, cmd_wdata} = 34'h0;
        repeat (8) @(negedge sys_clk);
        rst = 1'b0;
        xfer(2'h2, 1'b0, 32'h0000_0100);
        xfer(2'h0, 1'b0, 32'h1234_1234);
        idle();
        chk(64'(control_value), 64'h1234);
        xfer(2'h2, 1'b1, 32'h0);
        chk(64'(r), 64'h100);
        xfer(2'h3, 1'b1, 32'h0);
        chk(64'(r), 64'(32'h100 ^ K));
        // Two increment reads then a fixed read, which starts after the prefetch lands and fetches again
        for (int i = 0; i < 3; i++) begin
            xfer(i < 2 ? 2'h1 : 2'h3, 1'b1, 32'h0);
            chk(64'(r), 64'(32'h100 + 4 * i ^ K));
        end
        // Fill the commit buffer while memory stalls, then drain it
        xfer(2'h2, 1'b0, 32'h0000_0200);
        for (int i = 0; i < 16; i++) xfer(2'h3, 1'b0, 32'h5A00_0000 + i * 32'h0003_0001);
        xfer(2'h0, 1'b0, 32'h0077_0077);
        idle();
        chk(64'(commit_valid), 64'h1);
        for (int i = 0; i < 16; i++) begin
            chk(commit_word, {32'h200, 32'h5A00_0000 + i * 32'h0003_0001});
            commit_ready = 1'b1;
            @(negedge sys_clk);
            commit_ready = 1'b0;
            @(negedge sys_clk);
        end
        chk(64'(commit_valid), 64'h0);
        end_of_test();
    end
    // Guard against a hang; about 25 word accesses of under 45 cycles each
    initial begin
        repeat (4000) @(posedge sys_clk);
        errors++;
        $display("unexpected at %0t: watchdog expired", $time);
        end_of_test();
    end
endmodule : host_port_interface_test
